// file: sleep_ctrl_pkg.sv
package sleep_ctrl_pkg;
    // register offsets (i/o address space)
    localparam logic [7:0] CORE_CTRL_ADDR = 8'h35;
    localparam logic [7:0] CLK_STOP_ADDR  = 8'h20;
    // core control register fields
    localparam int         ARM_BIT        = 5;
    localparam int         MODE_LSB       = 3;
    localparam logic [7:0] CORE_CTRL_MASK = 8'h7b; // bits 7 and 2 read zero
    localparam logic [7:0] CORE_CTRL_RST  = 8'h00;
    // peripheral clock stop fields
    localparam int         STOP_TIM1      = 3;
    localparam int         STOP_TIM0      = 2;
    localparam int         STOP_USI       = 1;
    localparam int         STOP_CONV      = 0;
    localparam logic [7:0] CLK_STOP_MASK  = 8'h0f; // upper four bits read zero
    localparam logic [7:0] CLK_STOP_RST   = 8'h00;
    // sleep mode codes
    localparam logic [1:0] MODE_IDLE      = 2'h0;
    localparam logic [1:0] MODE_NOISE     = 2'h1;
    localparam logic [1:0] MODE_PDOWN     = 2'h2;
    localparam logic [1:0] MODE_STBY      = 2'h3;
    // wake timing in clock cycles
    localparam logic [3:0] IRQ_HOLD_CYC   = 4'h4;
    localparam logic [3:0] STBY_WAKE_CYC  = 4'h6;
    // wake source vector bit positions
    localparam int         WK_EXT0        = 0;
    localparam int         WK_EXT1        = 1;
    localparam int         WK_PCINT       = 2;
    localparam int         WK_SPM         = 3;
    localparam int         WK_CONV        = 4;
    localparam int         WK_USI         = 5;
    localparam int         WK_OTHER       = 6;
    localparam int         WK_WDT         = 7;
    localparam int         WK_WIDTH       = 8;

    typedef enum logic [2:0] {
        ST_RUN    = 3'b000,
        ST_SLEEP  = 3'b001,
        ST_OSC    = 3'b010,
        ST_HOLD   = 3'b011,
        ST_RESUME = 3'b100
    } pm_state_e;
endpackage : sleep_ctrl_pkg

// file: sleep_ctrl.sv
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/10ps

// wake sequencer states
// run: core clocks on, sleep instruction sampled
// sleep: domains gated per the latched mode
// osc: main source restarts, counted in cycles
// hold: core held after the source is stable
// resume: one cycle to release the core
// back to run once resume has passed
//
// mode latch
// the mode is captured when sleep is taken
// later writes to the control register
// do not disturb a sleep already in progress
// standby without a crystal option drops
// to power-down so the source is not kept
//
// entry timing
// edge n: sleep instruction and arm bit seen
// edge n+1: state enters sleep
// edge n+1: conversion start pulse launched
// edge n+2: clock gate outputs go low
// edge n+2: sleeping and core hold rise
// an unarmed instruction leaves state in run
// an instruction while asleep is ignored
//
// wake timing
// the wake source is sampled while in sleep
// osc state lasts one cycle, or the
// oscillator start count after power-down
// hold lasts the interrupt hold count
// standby sets hold to its wake count less two
// the handler pulse follows the hold state
// sleeping falls in the same output cycle
//
// wake filtering
// idle accepts any enabled pending source
// noise mode adds self-program and converter
// sources to the deep-mode set
// deep modes accept pin change, serial start,
// watchdog and level-configured pin requests
// an edge-configured pin request is dropped
// the partner must hold a level request
// until the handler pulse is seen
//
// reset during sleep
// a reset source while asleep forces run
// the counter and pending handler are cleared
// the vector reset pulse tells the core to
// restart from the reset vector
// a reset source while awake is not flagged
// here; the core sees it directly
//
// clock gates
// outputs are high while a domain runs
// core and program memory share one enable
// the fast peripheral clock follows io
// the converter clock runs in idle and noise
// the phase lock clock runs in idle and noise
// only when it is the system clock
// the main source stops in power-down only
// during osc and hold only the core stays
// gated, so the source can settle first
//
// peripheral stops
// stop bits gate clocks only while io runs
// in deeper modes the io gate already stops
// access enables follow the stop bits always
// so a stopped peripheral cannot be touched
// a cleared stop bit restores the clock and
// the peripheral carries on where it left
// nothing here resets a stopped peripheral
//
// converter
// a conversion start is pulsed on entry to
// idle or noise mode when converter is on
// the extended flag rises with the enable
// and is cleared by the next start pulse
// a rise and a start in one cycle keep
// the flag set, so the set wins
//
// comparator and reference
// the comparator is cut in the deep modes
// unless it is fed from the reference
// the reference follows the comparator
// and is not gated by sleep
//
// register port
// writes take effect on the strobe edge
// reads return data one cycle later
// reserved bits are masked on write and read
// unmapped addresses read zero
// read data is zero when no read is pending
//
// state retention
// no register outside this block is touched
// by sleep entry or wake
// the working registers and static memory
// keep their contents because only clocks
// are gated, never a reset
//
// hazards
// gate outputs are registered so enables
// change only on clock edges, glitch free
// an illegal state code returns to run
// the counter is four bits; counts above
// fifteen do not fit
// oscillator start count must be one or more
// a count of zero is treated as one
//
// status
// sleeping mirrors core hold for status use
// both fall in the cycle of the handler pulse
//
// limits
// the block has a single clock and the
// outputs are meant for clock gate cells
// it does not model the gated clocks
// themselves or any analog behaviour
module sleep_ctrl #(
    parameter logic [3:0] OSC_START_CYC = 4'h2
) (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_resetn,
    // register port
    input  wire logic [7:0]            i_addr,
    input  wire logic [7:0]            i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [7:0]            o_rdata,
    // core side
    input  wire logic                  i_sleep_instr,
    input  wire logic                  i_wake_reset,
    input  wire logic [7:0]            i_wake_irq,
    input  wire logic                  i_ext0_level,
    input  wire logic                  i_ext1_level,
    input  wire logic                  i_pll_is_sys,
    input  wire logic                  i_crystal_sel,
    input  wire logic                  i_conv_enabled,
    input  wire logic                  i_comp_enabled,
    input  wire logic                  i_comp_uses_ref,
    output logic                       o_core_hold,
    output logic                       o_irq_go,
    output logic                       o_vector_reset,
    output logic                       o_sleeping,
    // clock gates, high = domain runs
    output logic                       o_core_clock_domain_en,
    output logic                       o_program_memory_clock_domain_en,
    output logic                       o_io_clock_domain_en,
    output logic                       o_converter_clock_domain_en,
    output logic                       o_fast_peripheral_clock_domain_en,
    output logic                       o_phase_lock_clock_domain_en,
    output logic                       o_main_osc_en,
    output logic [3:0]                 o_periph_clk_en,
    output logic [3:0]                 o_periph_access_en,
    output logic                       o_conv_start,
    output logic                       o_conv_extended,
    output logic                       o_comp_enable,
    output logic                       o_vref_enable
);
    sleep_ctrl_pkg::pm_state_e state_reg, state_next;
    logic [7:0] core_ctrl_reg;
    logic [7:0] clk_stop_reg;
    logic [3:0] cnt_reg, cnt_next;
    logic [1:0] mode_reg;
    logic       irq_wake_reg;
    logic       conv_en_d_reg;
    logic       conv_ext_reg;
    logic [7:0] rdata_next;

    // register decode
    wire        sel_core  = (i_addr == sleep_ctrl_pkg::CORE_CTRL_ADDR);
    wire        sel_stop  = (i_addr == sleep_ctrl_pkg::CLK_STOP_ADDR);
    wire        arm       = core_ctrl_reg[sleep_ctrl_pkg::ARM_BIT];
    wire [1:0]  mode_sel  = core_ctrl_reg[sleep_ctrl_pkg::MODE_LSB +: 2];
    wire        go_sleep  = i_sleep_instr && arm && (state_reg == sleep_ctrl_pkg::ST_RUN);

    // standby only when a crystal option is selected, else treat as power-down
    wire [1:0]  mode_eff  = (mode_sel == sleep_ctrl_pkg::MODE_STBY && !i_crystal_sel)
                            ? sleep_ctrl_pkg::MODE_PDOWN : mode_sel;

    // wake qualification per mode; deep modes take the external pins as level interrupts only
    wire        lvl0      = i_wake_irq[sleep_ctrl_pkg::WK_EXT0] && i_ext0_level;
    wire        lvl1      = i_wake_irq[sleep_ctrl_pkg::WK_EXT1] && i_ext1_level;
    wire        wake_deep = lvl0 || lvl1 || i_wake_irq[sleep_ctrl_pkg::WK_PCINT]
                            || i_wake_irq[sleep_ctrl_pkg::WK_USI]
                            || i_wake_irq[sleep_ctrl_pkg::WK_WDT];
    wire        wake_nois = wake_deep || i_wake_irq[sleep_ctrl_pkg::WK_SPM]
                            || i_wake_irq[sleep_ctrl_pkg::WK_CONV];
    wire        wake_idle = |i_wake_irq;
    wire        wake_irq  = (mode_reg == sleep_ctrl_pkg::MODE_IDLE)  ? wake_idle :
                            (mode_reg == sleep_ctrl_pkg::MODE_NOISE) ? wake_nois : wake_deep;

    // oscillator restart time depends on mode
    wire [3:0]  osc_cyc   = (mode_reg == sleep_ctrl_pkg::MODE_PDOWN) ? OSC_START_CYC
                            : 4'h1;

    // wake sequencer: sleep, oscillator start, interrupt hold
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        unique case (state_reg)
            sleep_ctrl_pkg::ST_RUN: begin
                if (go_sleep) begin
                    state_next = sleep_ctrl_pkg::ST_SLEEP;
                end
            end
            sleep_ctrl_pkg::ST_SLEEP: begin
                if (wake_irq) begin
                    state_next = sleep_ctrl_pkg::ST_OSC;
                    cnt_next   = osc_cyc;
                end
            end
            sleep_ctrl_pkg::ST_OSC: begin
                if (cnt_reg <= 4'h1) begin
                    state_next = sleep_ctrl_pkg::ST_HOLD;
                    cnt_next   = (mode_reg == sleep_ctrl_pkg::MODE_STBY)
                                 ? sleep_ctrl_pkg::STBY_WAKE_CYC - 4'h2
                                 : sleep_ctrl_pkg::IRQ_HOLD_CYC;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            sleep_ctrl_pkg::ST_HOLD: begin
                if (cnt_reg <= 4'h1) begin
                    state_next = sleep_ctrl_pkg::ST_RESUME;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            sleep_ctrl_pkg::ST_RESUME: begin
                state_next = sleep_ctrl_pkg::ST_RUN;
            end
            default: begin
                state_next = sleep_ctrl_pkg::ST_RUN;
            end
        endcase
    end

    // clock enables per state and mode
    wire        asleep    = (state_reg != sleep_ctrl_pkg::ST_RUN)
                            && (state_reg != sleep_ctrl_pkg::ST_RESUME);
    wire        in_sleep  = (state_reg == sleep_ctrl_pkg::ST_SLEEP);
    wire        m_idle    = (mode_reg == sleep_ctrl_pkg::MODE_IDLE);
    wire        m_noise   = (mode_reg == sleep_ctrl_pkg::MODE_NOISE);
    wire        m_stby    = (mode_reg == sleep_ctrl_pkg::MODE_STBY);
    wire        deep      = !m_idle && !m_noise;
    wire        core_en_n = !asleep;
    wire        io_en_n   = !in_sleep || m_idle;
    wire        conv_en_n = !in_sleep || m_idle || m_noise;
    wire        pll_en_n  = !in_sleep || ((m_idle || m_noise) && i_pll_is_sys);
    wire        osc_en_n  = !in_sleep || !deep || m_stby;
    // stop bits gate only while the io clock itself would run
    wire [3:0]  stop_bits = clk_stop_reg[3:0];
    wire [3:0]  pclk_n    = io_en_n ? ~stop_bits : 4'h0;
    wire        conv_strt = go_sleep && i_conv_enabled
                            && (mode_sel == sleep_ctrl_pkg::MODE_IDLE
                                || mode_sel == sleep_ctrl_pkg::MODE_NOISE);
    wire        comp_n    = i_comp_enabled && (!(in_sleep && deep) || i_comp_uses_ref);
    wire        vref_n    = i_comp_enabled && i_comp_uses_ref;

    // read data; masked register bits read zero, unmapped reads zero
    always_comb begin
        rdata_next = 8'h00;
        if (i_rd && sel_core) begin
            rdata_next = core_ctrl_reg & sleep_ctrl_pkg::CORE_CTRL_MASK;
        end else if (i_rd && sel_stop) begin
            rdata_next = clk_stop_reg & sleep_ctrl_pkg::CLK_STOP_MASK;
        end
    end

    // registers; a reset source while asleep returns to run and flags vector reset
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            state_reg     <= sleep_ctrl_pkg::ST_RUN;
            core_ctrl_reg <= sleep_ctrl_pkg::CORE_CTRL_RST;
            clk_stop_reg  <= sleep_ctrl_pkg::CLK_STOP_RST;
            cnt_reg       <= 4'h0;
            mode_reg      <= sleep_ctrl_pkg::MODE_IDLE;
            conv_en_d_reg <= 1'b0;
            conv_ext_reg  <= 1'b0;
            irq_wake_reg  <= 1'b0;
        end else if (i_wake_reset && asleep) begin
            state_reg     <= sleep_ctrl_pkg::ST_RUN;
            cnt_reg       <= 4'h0;
            irq_wake_reg  <= 1'b0;
        end else begin
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            irq_wake_reg  <= (state_reg == sleep_ctrl_pkg::ST_HOLD)
                             && (state_next == sleep_ctrl_pkg::ST_RESUME);
            if (go_sleep) begin
                mode_reg <= mode_eff;
            end
            if (i_wr && sel_core) begin
                core_ctrl_reg <= i_wdata & sleep_ctrl_pkg::CORE_CTRL_MASK;
            end
            if (i_wr && sel_stop) begin
                clk_stop_reg <= i_wdata & sleep_ctrl_pkg::CLK_STOP_MASK;
            end
            conv_en_d_reg <= i_conv_enabled;
            if (i_conv_enabled && !conv_en_d_reg) begin
                conv_ext_reg <= 1'b1;
            end else if (o_conv_start) begin
                conv_ext_reg <= 1'b0;
            end
        end
    end

    // output flops
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_rdata                           <= 8'h00;
            o_core_hold                       <= 1'b0;
            o_irq_go                          <= 1'b0;
            o_vector_reset                    <= 1'b0;
            o_sleeping                        <= 1'b0;
            o_core_clock_domain_en            <= 1'b1;
            o_program_memory_clock_domain_en  <= 1'b1;
            o_io_clock_domain_en              <= 1'b1;
            o_converter_clock_domain_en       <= 1'b1;
            o_fast_peripheral_clock_domain_en <= 1'b1;
            o_phase_lock_clock_domain_en      <= 1'b1;
            o_main_osc_en                     <= 1'b1;
            o_periph_clk_en                   <= 4'hf;
            o_periph_access_en                <= 4'hf;
            o_conv_start                      <= 1'b0;
            o_conv_extended                   <= 1'b0;
            o_comp_enable                     <= 1'b0;
            o_vref_enable                     <= 1'b0;
        end else begin
            o_rdata                           <= rdata_next;
            // core halted but state kept; nothing is cleared on wake
            o_core_hold                       <= asleep;
            o_irq_go                          <= irq_wake_reg;
            o_vector_reset                    <= i_wake_reset && asleep;
            o_sleeping                        <= asleep;
            o_core_clock_domain_en            <= core_en_n;
            o_program_memory_clock_domain_en  <= core_en_n;
            o_io_clock_domain_en              <= io_en_n;
            o_converter_clock_domain_en       <= conv_en_n;
            o_fast_peripheral_clock_domain_en <= io_en_n;
            o_phase_lock_clock_domain_en      <= pll_en_n;
            o_main_osc_en                     <= osc_en_n;
            o_periph_clk_en                   <= pclk_n;
            o_periph_access_en                <= ~stop_bits;
            o_conv_start                      <= conv_strt;
            o_conv_extended                   <= conv_ext_reg;
            o_comp_enable                     <= comp_n;
            o_vref_enable                     <= vref_n;
        end
    end
endmodule : sleep_ctrl

// file: sleep_ctrl_monitor.sv
`timescale 1ns/10ps
module sleep_ctrl_monitor (
    input  wire logic       i_clk_sys,
    input  wire logic       i_resetn,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_sleep_instr,
    input  wire logic       i_wake_reset,
    input  wire logic [7:0] i_wake_irq,
    input  wire logic       i_ext0_level,
    input  wire logic       i_ext1_level,
    input  wire logic       i_crystal_sel,
    input  wire logic       i_conv_enabled,
    input  wire logic       o_sleeping,
    input  wire logic       o_irq_go,
    input  wire logic       o_vector_reset,
    input  wire logic       o_conv_start,
    input  wire logic       o_core_clock_domain_en,
    input  wire logic       o_program_memory_clock_domain_en,
    input  wire logic       o_io_clock_domain_en,
    input  wire logic       o_converter_clock_domain_en,
    input  wire logic       o_main_osc_en,
    input  wire logic [3:0] o_periph_clk_en,
    input  wire logic [3:0] o_periph_access_en
);
    logic [7:0] ctrl_reg, stop_reg;
    logic [1:0] quiet_reg;
    logic       woke_reg;
    // shadow decode of the register writes and wake sources
    wire logic [1:0] mode = ctrl_reg[4:3];
    wire logic       arm  = ctrl_reg[5];
    wire logic       stop_wr = i_wr && i_addr == sleep_ctrl_pkg::CLK_STOP_ADDR;
    wire logic       nap_ok = i_sleep_instr && !o_sleeping && !i_wake_reset && i_wake_irq == 8'h00;
    wire logic       deep_wake = i_wake_reset | (i_wake_irq[0] & i_ext0_level)
                     | (i_wake_irq[1] & i_ext1_level) | i_wake_irq[2] | i_wake_irq[5] | i_wake_irq[7];
    wire logic       core_off = !o_core_clock_domain_en && !o_program_memory_clock_domain_en;
    // shadow registers, settle counter and wake memory
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            ctrl_reg <= 8'h00;
            stop_reg <= 8'h00;
            quiet_reg <= 2'h0;
            woke_reg <= 1'b0;
        end else begin
            if (i_wr && i_addr == sleep_ctrl_pkg::CORE_CTRL_ADDR) ctrl_reg <= i_wdata;
            if (stop_wr) stop_reg <= i_wdata;
            quiet_reg <= stop_wr ? 2'h0 : (quiet_reg == 2'h3 ? 2'h3 : quiet_reg + 2'h1);
            woke_reg <= o_sleeping && (woke_reg || deep_wake || (mode == 2'h0 && i_wake_irq != 8'h00));
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    sequence s_armed_request;
        nap_ok && arm;
    endsequence
    a_armed_sleep_enters: assert property (s_armed_request |-> ##2 o_sleeping)
        else $error("armed sleep not entered");
    a_unarmed_no_op: assert property (nap_ok && !arm |-> ##2 !o_sleeping)
        else $error("unarmed sleep changed state");
    a_idle_clock_gates: assert property ($rose(o_sleeping) && mode == 2'h0 |-> core_off
        && o_io_clock_domain_en && o_converter_clock_domain_en && o_main_osc_en)
        else $error("idle gating wrong");
    a_noise_clock_gates: assert property ($rose(o_sleeping) && mode == 2'h1 |-> core_off
        && !o_io_clock_domain_en && o_converter_clock_domain_en && o_main_osc_en)
        else $error("noise gating wrong");
    a_pdown_clock_gates: assert property ($rose(o_sleeping) && (mode == 2'h2
        || (mode == 2'h3 && !i_crystal_sel)) |-> core_off && !o_converter_clock_domain_en
        && !o_io_clock_domain_en && !o_main_osc_en) else $error("power-down gating wrong");
    a_stby_keeps_osc: assert property ($rose(o_sleeping) && mode == 2'h3 && i_crystal_sel
        |-> core_off && !o_converter_clock_domain_en && o_main_osc_en)
        else $error("standby gating wrong");
    a_conv_auto_start: assert property (s_armed_request ##0 (!mode[1] && i_conv_enabled)
        |-> ##1 o_conv_start) else $error("conversion not started");
    a_deep_wake_filter: assert property (o_sleeping && mode[1] && !woke_reg && !deep_wake
        |=> o_sleeping) else $error("woke from a filtered source");
    a_reset_vector_cause: assert property (o_vector_reset |-> $past(o_sleeping))
        else $error("reset vector without sleep");
    a_stop_blocks_access: assert property (quiet_reg == 2'h3 && !o_sleeping
        |-> o_periph_access_en == ~stop_reg[3:0] && o_periph_clk_en == ~stop_reg[3:0])
        else $error("peripheral stop mismatch");
    a_idle_wake_bound: assert property (o_sleeping && !woke_reg && mode == 2'h0
        && i_wake_irq[6] |-> ##[4:12] o_irq_go) else $error("idle wake late or early");
endmodule : sleep_ctrl_monitor

// file: core_side_model.sv
`timescale 1ns/10ps
module core_side_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_resetn,
    input  wire logic       i_raise,
    input  wire logic [7:0] i_src,
    input  wire logic       i_irq_go,
    input  wire logic       i_vector_reset,
    output logic      [7:0] o_wake_irq
);
    // level request held until the handler runs or the core restarts
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn || i_irq_go || i_vector_reset) o_wake_irq <= 8'h00;
        else if (i_raise) o_wake_irq <= i_src;
    end
endmodule : core_side_model

// file: sleep_ctrl_test.sv
`timescale 1ns/10ps
module sleep_ctrl_test;
    logic i_clk_sys = 0, i_resetn = 0, i_wr = 0, i_rd = 0, i_sleep_instr = 0, i_wake_reset = 0;
    logic i_ext0_level = 0, i_ext1_level = 0, i_pll_is_sys = 0, i_crystal_sel = 1;
    logic i_conv_enabled = 1, i_comp_enabled = 1, i_comp_uses_ref = 0, raise = 0;
    logic [7:0] i_addr = 0, i_wdata = 0, src = 0, o_rdata, i_wake_irq;
    logic o_core_hold, o_irq_go, o_vector_reset, o_sleeping, o_core_clock_domain_en;
    logic o_program_memory_clock_domain_en, o_io_clock_domain_en, o_converter_clock_domain_en;
    logic o_fast_peripheral_clock_domain_en, o_phase_lock_clock_domain_en, o_main_osc_en;
    logic o_conv_start, o_conv_extended, o_comp_enable, o_vref_enable;
    logic [3:0] o_periph_clk_en, o_periph_access_en;
    logic [31:0] lfsr = 32'h0001338e;
    int errors = 0, tests_run = 0, cyc = 0, n;
    sleep_ctrl #(.OSC_START_CYC(4'h1)) i_dut (.*);
    core_side_model i_core (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_raise(raise),
        .i_src(src), .i_irq_go(o_irq_go), .i_vector_reset(o_vector_reset), .o_wake_irq(i_wake_irq));
    initial forever #50 i_clk_sys = ~i_clk_sys;
    // hang guard
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            conclude();
        end
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // expected {core, flash, io, conv, osc} enables while asleep
    function automatic logic [7:0] exp_gates(input logic [1:0] m);
        case (m)
            2'h0: return 8'h07;
            2'h1: return 8'h03;
            2'h2: return 8'h00;
            default: return {7'h0, i_crystal_sel};
        endcase
    endfunction : exp_gates
    task check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys) {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
        @(posedge i_clk_sys) i_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys) {i_addr, i_rd} <= {a, 1'b1};
        @(posedge i_clk_sys) i_rd <= 1'b0;
        @(negedge i_clk_sys) check(o_rdata, exp);
    endtask : rd
    task nap(input logic [7:0] ctrl);
        wr(8'h35, ctrl);
        @(posedge i_clk_sys) i_sleep_instr <= 1'b1;
        @(posedge i_clk_sys) i_sleep_instr <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
    endtask : nap
    task wake(input logic [7:0] s, input bit vec);
        @(posedge i_clk_sys) {src, raise, i_wake_reset} <= {s, 1'b1, vec};
        @(posedge i_clk_sys) {raise, i_wake_reset} <= 2'b00;
        n = 1;
        while ((vec ? o_vector_reset : o_irq_go) !== 1'b1 && n < 40) begin
            @(negedge i_clk_sys);
            n++;
        end
    endtask : wake
    task conclude();
        $display("counts errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    initial begin
        repeat (4) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        rd(8'h35, 8'h00);
        rd(8'h20, 8'h00);
        wr(8'h35, 8'hff);
        rd(8'h35, 8'h7b);
        wr(8'h7e, 8'hff);
        rd(8'h7e, 8'h00);
        repeat (8) begin
            lfsr = lfsr_next(lfsr);
            i_pll_is_sys <= lfsr[4];
            i_comp_uses_ref <= lfsr[5];
            wr(8'h20, lfsr[7:0]);
            rd(8'h20, lfsr[7:0] & 8'h0f);
            check({4'h0, o_periph_access_en}, {4'h0, ~lfsr[3:0]});
            check({4'h0, o_periph_clk_en}, {4'h0, ~lfsr[3:0]});
        end
        wr(8'h20, 8'h00);
        check({7'h0, o_conv_extended}, 8'h01);
        $display("register test done");
        nap(8'h18);
        check({7'h0, o_sleeping}, 8'h00);
        $display("unarmed sleep test done");
        for (int m = 0; m < 4; m++) begin
            nap(8'h20 | (8'(m) << 3));
            check({3'h0, o_core_clock_domain_en, o_program_memory_clock_domain_en,
                o_io_clock_domain_en, o_converter_clock_domain_en, o_main_osc_en}, exp_gates(2'(m)));
            check({6'h0, o_fast_peripheral_clock_domain_en, o_phase_lock_clock_domain_en},
                {6'h0, m == 0, m < 2 && i_pll_is_sys});
            check({6'h0, o_comp_enable, o_vref_enable},
                {6'h0, m < 2 || i_comp_uses_ref, i_comp_uses_ref});
            check({7'h0, o_core_hold}, 8'h01);
            wake(m == 0 ? 8'h40 : 8'h04, 1'b0);
            check({7'h0, o_irq_go}, 8'h01);
            check({7'h0, n >= 5}, 8'h01);
            // model edge, output flop and loop entry add three to the six cycles
            if (m == 3) check({7'h0, n <= 4'(sleep_ctrl_pkg::STBY_WAKE_CYC) + 3}, 8'h01);
            repeat (2) @(posedge i_clk_sys);
        end
        $display("mode loop test done");
        nap(8'h30);
        wake(8'h01, 1'b0);
        check({7'h0, o_sleeping}, 8'h01);
        wake(8'h00, 1'b1);
        check({7'h0, o_vector_reset}, 8'h01);
        $display("reset wake test done");
        conclude();
    end
endmodule : sleep_ctrl_test
bind sleep_ctrl sleep_ctrl_monitor i_mon (.*);
